// ---- core/dicr_pkg.sv ----
package dicr_pkg;
  localparam int unsigned DICR_NUM_INPUTS = 5;
  localparam int unsigned DICR_NUM_ROUTES = 32;
  localparam int unsigned DICR_CLK_HZ = 40000000;
  localparam int unsigned DICR_SAMPLE_MS = 1;
  localparam int unsigned DICR_SAMPLE_CYCLES = DICR_CLK_HZ / 1000 * DICR_SAMPLE_MS;

  // Register byte offsets
  localparam logic [11:0] DICR_SUMMARY_OFS = 12'h000;
  localparam logic [11:0] DICR_SFEN_OFS = 12'h004;
  localparam logic [11:0] DICR_INV_OFS = 12'h008;
  localparam logic [11:0] DICR_FEN_OFS = 12'h00C;
  localparam logic [11:0] DICR_FVAL_OFS = 12'h010;
  localparam logic [11:0] DICR_RAW_OFS = 12'h014;
  localparam logic [11:0] DICR_THR_OFS = 12'h018;
  localparam logic [11:0] DICR_RTEN_OFS = 12'h01C;
  localparam logic [11:0] DICR_STATUS_OFS = 12'h020;
  localparam logic [11:0] DICR_TABLE_OFS = 12'h100;
  localparam logic [11:0] DICR_TABLE_END = 12'h17C;

  // Summary special-function bit positions and level-bit base
  localparam int unsigned DICR_SF_NEG_LIM = 0;
  localparam int unsigned DICR_SF_POS_LIM = 1;
  localparam int unsigned DICR_SF_HOME = 2;
  localparam int unsigned DICR_SF_INTERLOCK = 3;
  localparam int unsigned DICR_LEVEL_BASE = 16;

  // Routing source codes
  localparam logic [7:0] DICR_SRC_ZERO = 8'h00;
  localparam logic [7:0] DICR_SRC_PHYS_LAST = 8'h10;
  localparam logic [7:0] DICR_SRC_HALL_U = 8'h41;
  localparam logic [7:0] DICR_SRC_USB = 8'h47;
  localparam logic [7:0] DICR_SRC_INV_BIT = 8'h80;

  localparam logic [31:0] DICR_REG_RESET = 32'h0000_0000;
endpackage

// ---- core/dicr_sampler.sv ----
`timescale 1ns/100ps
module dicr_sampler (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [4:0] pin_i,
  output logic tick_o,
  output logic [4:0] sample_o
);
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] smp;
    logic [15:0] cnt;
    logic tick;
  } dicr_smp_s;
  dicr_smp_s st_q;
  dicr_smp_s st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.tick = 1'b0;
    if (st_q.cnt == 16'(dicr_pkg::DICR_SAMPLE_CYCLES - 1)) begin
      st_d.cnt = 16'h0000;
      st_d.tick = 1'b1;
      // Only one sample a millisecond; shorter blips are missed
      st_d.smp = st_q.s2;
    end else begin
      st_d.cnt = st_q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign tick_o = st_q.tick;
  assign sample_o = st_q.smp;

  tick_period_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    st_q.tick |-> ##1 !st_q.tick [*8])
    else $error("sample tick too frequent");
  sample_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !st_q.tick |-> $stable(st_q.smp))
    else $error("sample changed between ticks");
endmodule

// ---- core/dicr_router.sv ----
`timescale 1ns/100ps
module dicr_router (
  input wire logic [7:0] code_i,
  input wire logic [15:0] phys_i,
  input wire logic [6:0] aux_i,
  output logic bit_o
);
  logic base;
  logic [6:0] low;

  always_comb begin
    low = code_i[6:0];
    base = 1'b0;
    // Source decode, bit 7 inverts
    if (low != 7'h00 && low <= dicr_pkg::DICR_SRC_PHYS_LAST[6:0]) begin
      base = phys_i[4'(low - 7'h01)];
    end else if (low >= dicr_pkg::DICR_SRC_HALL_U[6:0] && low <= dicr_pkg::DICR_SRC_USB[6:0]) begin
      base = aux_i[3'(low - dicr_pkg::DICR_SRC_HALL_U[6:0])];
    end
    bit_o = base ^ code_i[7];
  end
endmodule

// ---- core/dicr_top.sv ----
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/100ps
// How it works
// - Special and level summary bits for inputs 1-3, level bit only for inputs 4-5
// - Level bit 15+n follows input n while routing is off
// - Sample once per millisecond, ignore shorter pulses
// - Special enable gates bits 0-2 only while routing is off; its bit 3 enables the interlock fault
// - Bits 0-3: neg limit, pos limit, home, interlock
// - Inversion bit selects normally-closed logic
// - Inversion skipped for step clock/direction use
// - Force enable replaces sampled input value
// - Force value supplies forced input level
// - Raw register shows unmodified input states
// - Threshold bit picks 5 V or 24 V
// - Inputs 1-3 carry limit and home functions
// - Routing enable switches to table selection
// - Enabling routing preloads table with inputs 1-5 at entries 0-4 and 16-20
// - Table entry k drives summary bit k
// - Source codes: zero, physical, hall, encoder, USB
// - Code 80 is one; C-range inverts sources
// - Interlock low raises error and fault reaction
// - Bit 0 neg limit, bit 16 input 1 level
module dicr_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [4:0] pin_i,
  input wire logic [6:0] aux_i,
  input wire logic step_mode_i,
  output logic [4:0] thr_24v_o,
  output logic neg_limit_o,
  output logic pos_limit_o,
  output logic home_o,
  output logic interlock_fault_o
);
  typedef struct packed {
    logic [31:0] summary;
    logic [31:0] sfen;
    logic [31:0] inv;
    logic [31:0] fen;
    logic [31:0] fval;
    logic [31:0] thr;
    logic [7:0] rten;
    logic fault;
    logic [31:0] rdata;
    logic [31:0][7:0] table_e;
  } dicr_state_s;

  dicr_state_s st_q;
  dicr_state_s st_d;
  logic tick;
  logic [4:0] sample;
  logic [6:0] aux_s1;
  logic [6:0] aux_s2;
  logic [4:0] level;
  logic [31:0] fixed_word;
  logic [31:0] routed_word;
  logic [15:0] phys_vec;
  logic wr_en;
  logic rd_en;
  logic mapped;
  logic [4:0] tbl_idx;

  dicr_sampler u_sampler (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(pin_i),
    .tick_o(tick),
    .sample_o(sample)
  );

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aux_s1 <= 7'h00;
      aux_s2 <= 7'h00;
    end else begin
      aux_s1 <= aux_i;
      aux_s2 <= aux_s1;
    end
  end
  // Default table: inputs 1-5 at entries 0-4 and 16-20, others zero
  function automatic logic [7:0] preload(input int unsigned k);
    if (k < dicr_pkg::DICR_NUM_INPUTS) begin
      preload = 8'(k + 1);
    end else if (k >= dicr_pkg::DICR_LEVEL_BASE && k < dicr_pkg::DICR_LEVEL_BASE + dicr_pkg::DICR_NUM_INPUTS) begin
      preload = 8'(k - dicr_pkg::DICR_LEVEL_BASE + 1);
    end else begin
      preload = dicr_pkg::DICR_SRC_ZERO;
    end
  endfunction

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      // Force first, then inversion unless used for stepping
      level[i] = (st_q.fen[i] ? st_q.fval[i] : sample[i]) ^
                 (st_q.inv[i] && !(step_mode_i && i < 2));
    end
  end

  assign phys_vec = {11'h000, level};

  always_comb begin
    fixed_word = 32'h0000_0000;
    for (int i = 0; i < 5; i++) begin
      fixed_word[dicr_pkg::DICR_LEVEL_BASE + i] = level[i];
    end
    // Only inputs 1-3 have special functions, gated by enable
    fixed_word[dicr_pkg::DICR_SF_NEG_LIM] = level[0] & st_q.sfen[dicr_pkg::DICR_SF_NEG_LIM] & !step_mode_i;
    fixed_word[dicr_pkg::DICR_SF_POS_LIM] = level[1] & st_q.sfen[dicr_pkg::DICR_SF_POS_LIM] & !step_mode_i;
    fixed_word[dicr_pkg::DICR_SF_HOME] = level[2] & st_q.sfen[dicr_pkg::DICR_SF_HOME];
  end

  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_route
      dicr_router u_router (
        .code_i(st_q.table_e[g]),
        .phys_i(phys_vec),
        .aux_i(aux_s2),
        .bit_o(routed_word[g])
      );
    end
  endgenerate

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign tbl_idx = paddr_i[6:2];

  always_comb begin
    mapped = 1'b1;
    case (paddr_i)
      dicr_pkg::DICR_SUMMARY_OFS, dicr_pkg::DICR_SFEN_OFS, dicr_pkg::DICR_INV_OFS,
      dicr_pkg::DICR_FEN_OFS, dicr_pkg::DICR_FVAL_OFS, dicr_pkg::DICR_RAW_OFS,
      dicr_pkg::DICR_THR_OFS, dicr_pkg::DICR_RTEN_OFS, dicr_pkg::DICR_STATUS_OFS: mapped = 1'b1;
      default: mapped = (paddr_i >= dicr_pkg::DICR_TABLE_OFS) && (paddr_i <= dicr_pkg::DICR_TABLE_END)
                        && (paddr_i[1:0] == 2'b00);
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (tick) begin
      st_d.summary = st_q.rten[0] ? routed_word : fixed_word;
    end
    // Interlock only acts when its enable is set
    st_d.fault = st_q.sfen[dicr_pkg::DICR_SF_INTERLOCK] && !st_q.summary[dicr_pkg::DICR_SF_INTERLOCK];
    if (rd_en) begin
      case (paddr_i)
        dicr_pkg::DICR_SUMMARY_OFS: st_d.rdata = st_q.summary;
        dicr_pkg::DICR_SFEN_OFS: st_d.rdata = st_q.sfen;
        dicr_pkg::DICR_INV_OFS: st_d.rdata = st_q.inv;
        dicr_pkg::DICR_FEN_OFS: st_d.rdata = st_q.fen;
        dicr_pkg::DICR_FVAL_OFS: st_d.rdata = st_q.fval;
        dicr_pkg::DICR_RAW_OFS: st_d.rdata = {27'h0000000, sample};
        dicr_pkg::DICR_THR_OFS: st_d.rdata = st_q.thr;
        dicr_pkg::DICR_RTEN_OFS: st_d.rdata = {24'h000000, st_q.rten};
        dicr_pkg::DICR_STATUS_OFS: st_d.rdata = {31'h00000000, st_q.fault};
        default: st_d.rdata = mapped ? {24'h000000, st_q.table_e[tbl_idx]} : 32'h0000_0000;
      endcase
    end
    if (wr_en && mapped) begin
      case (paddr_i)
        dicr_pkg::DICR_SFEN_OFS: st_d.sfen = pwdata_i;
        dicr_pkg::DICR_INV_OFS: st_d.inv = pwdata_i;
        dicr_pkg::DICR_FEN_OFS: st_d.fen = pwdata_i;
        dicr_pkg::DICR_FVAL_OFS: st_d.fval = pwdata_i;
        dicr_pkg::DICR_THR_OFS: st_d.thr = pwdata_i;
        dicr_pkg::DICR_RTEN_OFS: begin
          st_d.rten = pwdata_i[7:0];
          if (pwdata_i[0] && !st_q.rten[0]) begin
            for (int k = 0; k < 32; k++) begin
              st_d.table_e[k] = preload(k);
            end
          end
        end
        dicr_pkg::DICR_SUMMARY_OFS, dicr_pkg::DICR_RAW_OFS, dicr_pkg::DICR_STATUS_OFS: begin
        end
        default: st_d.table_e[tbl_idx] = pwdata_i[7:0];
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata_o = st_q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign thr_24v_o = st_q.thr[4:0];
  assign neg_limit_o = st_q.summary[dicr_pkg::DICR_SF_NEG_LIM];
  assign pos_limit_o = st_q.summary[dicr_pkg::DICR_SF_POS_LIM];
  assign home_o = st_q.summary[dicr_pkg::DICR_SF_HOME];
  assign interlock_fault_o = st_q.fault;

  interlock_err_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (st_q.sfen[3] && !st_q.summary[3]) |=> interlock_fault_o)
    else $error("interlock fault missing");

  no_fault_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !st_q.sfen[3] |=> !interlock_fault_o)
    else $error("fault while interlock off");

  status_read_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_en && paddr_i == dicr_pkg::DICR_STATUS_OFS) |=> prdata_o == {31'h00000000, $past(st_q.fault)})
    else $error("status read wrong");

  level_bit_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && !st_q.rten[0]) |=> st_q.summary[16] == $past(level[0]))
    else $error("level bit wrong");

  upper_level_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && !st_q.rten[0]) |=> st_q.summary[31:16] == {11'h000, $past(level)})
    else $error("level half wrong");

  sf_gate_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && !st_q.rten[0] && !st_q.sfen[1]) |=> !st_q.summary[1])
    else $error("pos limit not gated");

  sf_pass_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && !st_q.rten[0] && st_q.sfen[2]) |=> st_q.summary[2] == $past(level[2]))
    else $error("home bit wrong");

  fixed_spare_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && !st_q.rten[0]) |=> st_q.summary[15:3] == 13'h0000)
    else $error("spare special bit set");

  step_gate_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    step_mode_i |-> fixed_word[1:0] == 2'b00)
    else $error("limit bit in step mode");

  step_skip_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (step_mode_i && st_q.fen[1:0] == 2'b00) |-> level[1:0] == sample[1:0])
    else $error("step input inverted");

  force_value_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (st_q.fen[3] && !st_q.inv[3]) |-> level[3] == st_q.fval[3])
    else $error("force ignored");

  force_inv_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (st_q.fen[4] && st_q.inv[4]) |-> level[4] == !st_q.fval[4])
    else $error("forced value not inverted");

  invert_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (st_q.inv[1] && !st_q.fen[1] && !step_mode_i) |-> level[1] == !sample[1])
    else $error("inversion wrong");

  raw_read_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_en && paddr_i == dicr_pkg::DICR_RAW_OFS) |=> prdata_o == {27'h0000000, $past(sample)})
    else $error("raw read wrong");

  thr_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == dicr_pkg::DICR_THR_OFS) |=> thr_24v_o == $past(pwdata_i[4:0]))
    else $error("threshold not applied");

  sfen_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == dicr_pkg::DICR_SFEN_OFS) |=> st_q.sfen == $past(pwdata_i))
    else $error("special enable not written");

  preload_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == dicr_pkg::DICR_RTEN_OFS && pwdata_i[0] && !st_q.rten[0])
    |=> st_q.table_e[16] == 8'h01)
    else $error("preload missing");

  preload_level_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == dicr_pkg::DICR_RTEN_OFS && pwdata_i[0] && !st_q.rten[0])
    |=> st_q.table_e[4] == 8'h05 && st_q.table_e[20] == 8'h05 && st_q.table_e[5] == 8'h00)
    else $error("preload table wrong");

  table_write_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (wr_en && paddr_i == dicr_pkg::DICR_TABLE_OFS) |=> st_q.table_e[0] == $past(pwdata_i[7:0]))
    else $error("table entry not written");

  table_read_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (rd_en && paddr_i == dicr_pkg::DICR_TABLE_END) |=> prdata_o == {24'h000000, $past(st_q.table_e[31])})
    else $error("table read wrong");

  route_phys_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && st_q.rten[0] && st_q.table_e[0] == 8'h01) |=> st_q.summary[0] == $past(level[0]))
    else $error("routed input wrong");

  route_zero_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && st_q.rten[0] && st_q.table_e[6] == 8'h00) |=> !st_q.summary[6])
    else $error("const zero wrong");

  route_aux_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && st_q.rten[0] && st_q.table_e[5] == 8'h47) |=> st_q.summary[5] == $past(aux_s2[6]))
    else $error("routed power signal wrong");

  routed_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && st_q.rten[0] && st_q.table_e[1] == 8'h80) |=> st_q.summary[1])
    else $error("const one wrong");

  route_inv_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    (tick && st_q.rten[0] && st_q.table_e[16] == 8'h81) |=> st_q.summary[16] != $past(level[0]))
    else $error("inverted source wrong");

  summary_hold_a: assert property (
    @(posedge clk_i) disable iff (!reset_n_i)
    !tick |=> $stable(st_q.summary))
    else $error("summary changed between ticks");

  cov_fault_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(interlock_fault_o));
  cov_route_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(st_q.rten[0]));
  cov_force_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tick && st_q.fen[4]);
  cov_step_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tick && step_mode_i);
  cov_inv_route_c: cover property (@(posedge clk_i) disable iff (!reset_n_i) tick && st_q.rten[0] && st_q.table_e[31][7]);
endmodule

// ---- testbench/dicr_switch_model.sv ----
`timescale 1ns/100ps
module dicr_switch_model (
  input wire logic clk_i,
  input wire logic [4:0] pin_req_i,
  input wire logic [6:0] aux_req_i,
  output logic [4:0] pin_o,
  output logic [6:0] aux_o
);
  // Changes land on a clock edge, one cycle after the request
  always @(posedge clk_i) begin
    pin_o <= pin_req_i;
    aux_o <= aux_req_i;
  end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
  logic clk_i, reset_n_i, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_o, e;
  logic pready_o, pslverr_o, neg_limit_o, pos_limit_o, home_o, interlock_fault_o, step_mode;
  logic [4:0] thr_24v_o, pin_req, pin, thr, p2;
  logic [6:0] aux_req, aux, ax;
  logic [32:0] notes[$];
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;

  dicr_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .pin_i(pin), .aux_i(aux), .step_mode_i(step_mode), .thr_24v_o(thr_24v_o), .neg_limit_o(neg_limit_o),
    .pos_limit_o(pos_limit_o), .home_o(home_o), .interlock_fault_o(interlock_fault_o));
  dicr_switch_model sw (.clk_i(clk_i), .pin_req_i(pin_req), .aux_req_i(aux_req), .pin_o(pin), .aux_o(aux));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (reset_n_i) cyc <= cyc + 1;

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Read notes are queued in setup so the monitor finds them at the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) notes.push_back(exp);
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_to(input int n);
    while (cyc < n) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (psel && penable && !pwrite && pready_o === 1'b1) check("apb read", {pslverr_o, prdata_o}, notes.pop_front());
  end

  // Two sample ticks fit in the run; the limit sits about 10000 cycles past the second
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end

  initial begin
    reset_n_i = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, pin_req, aux_req, step_mode} = '0;
    void'($urandom(32'h68B42CB1));
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    thr = 5'($urandom());
    pin_req <= 5'h0D;
    apb(1'b1, dicr_pkg::DICR_SFEN_OFS, 32'h0000_0005, 33'h0);
    apb(1'b1, dicr_pkg::DICR_INV_OFS, 32'h0000_0012, 33'h0);
    apb(1'b1, dicr_pkg::DICR_FEN_OFS, 32'h0000_0018, 33'h0);
    apb(1'b1, dicr_pkg::DICR_FVAL_OFS, 32'h0000_0010, 33'h0);
    apb(1'b1, dicr_pkg::DICR_THR_OFS, {27'h0, thr}, 33'h0);
    apb(1'b1, dicr_pkg::DICR_RAW_OFS, 32'hFFFF_FFFF, 33'h0);
    apb(1'b0, dicr_pkg::DICR_THR_OFS, 32'h0, {6'h00, 22'h0, thr});
    apb(1'b0, 12'h200, 32'h0, 33'h1_0000_0000);
    check("threshold pins", {28'h0, thr_24v_o}, {28'h0, thr});
    wait_to(40010);
    apb(1'b0, dicr_pkg::DICR_SUMMARY_OFS, 32'h0, 33'h0_0007_0005);
    apb(1'b0, dicr_pkg::DICR_RAW_OFS, 32'h0, 33'h0_0000_000D);
    check("limit and home", {30'h0, neg_limit_o, pos_limit_o, home_o}, 33'h5);
    p2 = 5'($urandom()) & 5'h17;
    ax = 7'($urandom());
    pin_req <= p2;
    aux_req <= ax;
    step_mode <= 1'b1;
    apb(1'b1, dicr_pkg::DICR_INV_OFS, 32'h0000_0005, 33'h0);
    apb(1'b1, dicr_pkg::DICR_FEN_OFS, 32'h0, 33'h0);
    apb(1'b1, dicr_pkg::DICR_SFEN_OFS, 32'h0000_0008, 33'h0);
    apb(1'b1, dicr_pkg::DICR_RTEN_OFS, 32'h0000_0001, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_OFS, 32'h01, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_OFS + 12'h004, 32'h80, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_OFS + 12'h00C, 32'h04, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_OFS + 12'h014, 32'h47, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_OFS + 12'h040, 32'h81, 33'h0);
    apb(1'b1, dicr_pkg::DICR_TABLE_END, 32'hC1, 33'h0);
    apb(1'b0, dicr_pkg::DICR_TABLE_END, 32'h0, 33'h0_0000_00C1);
    // A pulse far shorter than the sample period must leave no trace
    wait_to(60000);
    pin_req <= p2 ^ 5'h10;
    wait_to(60100);
    pin_req <= p2;
    wait_to(80010);
    e = 32'h0000_0002;
    e[0] = p2[0];
    e[2] = ~p2[2];
    e[3] = p2[3];
    e[4] = p2[4];
    e[5] = ax[6];
    e[16] = ~p2[0];
    e[20:17] = {p2[4:3], ~p2[2], p2[1]};
    e[31] = ~ax[0];
    apb(1'b0, dicr_pkg::DICR_SUMMARY_OFS, 32'h0, {1'b0, e});
    apb(1'b0, dicr_pkg::DICR_STATUS_OFS, 32'h0, 33'h0_0000_0001);
    check("fault pin", {32'h0, interlock_fault_o}, 33'h1);
    check("routed limits", {30'h0, neg_limit_o, pos_limit_o, home_o}, {30'h0, p2[0], 1'b1, ~p2[2]});
    wrap_up();
  end
endmodule
